//--- six_bit_port_with_change_irq.sv
// six-bit general purpose port with change detection behind wishbone
// assumes pins synchronous to ref_clk; sys_rst is master clear or brown-out
//
// Register access over Wishbone and the address map were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "six_bit_port_params.svh"

// Operation
// - five bidirectional pins and one input-only pin, data and direction bits
// - direction one tristates, zero drives latch
// - input-only pin never drives, direction reads one
// - port read gives pins, write sets latch
// - bit-set and bit-clear writes are read-modify-write on pins
// - master clear enabled makes input-only bit zero
// - direction still drives pins selected as analog
// - analog select forces digital reads to zero
// - analog select leaves output path untouched
// - upper two bits read zero
// - crystal mode forces oscillator direction bits one
// - per-pin pull-up except the input-only pin
// - pull-up off while pin is an output
// - power-on reset disables all pull-ups globally except the input-only one
// - input-only pull-up follows master clear enable
// - per-pin change enables cleared at power-on
// - mismatch against last read sets change flag
// - change event can wake from sleep
// - mismatch keeps setting flag; read then clear
// - last-read latch survives master clear, brown-out
// - change during the read still sets the flag
// - analog disables input, pull-up, change detect
// - pull-up bits need global pull-up permission
// - pull-up bit one on, zero off
// - change enable bit one on, zero off
module six_bit_port_with_change_irq
    import six_bit_port_pkg::*;
#(
    parameter int unsigned ADDR_W = `GP_ADDR_W
) (
    input wire logic ref_clk, // core clock
    input wire logic arst_n, // power-on reset
    input wire logic sys_rst, // master clear or brown-out
    input wire logic wb_cyc_i, // bus cycle
    input wire logic wb_stb_i, // strobe
    input wire logic wb_we_i, // write enable
    input wire logic [ADDR_W-1:0] wb_adr_i, // byte address
    input wire logic [3:0] wb_sel_i, // byte lanes
    input wire logic [31:0] wb_dat_i, // write data
    output logic [31:0] wb_dat_o, // read data
    output logic wb_ack_o, // acknowledge
    input wire logic [5:0] pin_i, // pin levels
    output logic [5:0] pin_o, // pin drive value
    output logic [5:0] pin_oe, // pin driver enable
    output logic [5:0] pullup_o, // weak pull-up on
    output logic change_flag_o, // port change flag
    output logic wake_o // wake request to sleep logic
);

    logic [5:0] latch_q, dir_q, wpu_q, ioc_q, last_q;
    logic [7:0] analog_select_low_q;
    logic master_clear_enable_q, xtal_q, flag_q, pudis_q, wake_q, ack_q;
    logic [31:0] rdat_q;
    pin_ctl_t ctl_q, ctl_d;
    bus_st_t st_q;
    reg_sel_t rsel;
    logic [5:0] ana, din, dir_eff, mism, wpu_rd;
    logic [5:0] set_val, clr_val, wr_val;
    logic [31:0] rdat_d;
    logic acc, wr, rd, port_touch, flag_clr;

    // analog channels sit on pins 0, 1, 2 and 4
    function automatic logic [5:0] ana_map(input logic [7:0] a);
        ana_map = {1'b0, a[3], 1'b0, a[2:0]};
    endfunction

    function automatic logic [31:0] word6(input logic [5:0] v);
        word6 = {26'h0, v};
    endfunction

    assign ana = ana_map(analog_select_low_q);

    always_comb begin
        din = pin_i & ~ana;
        din[`GP_IN_ONLY_BIT] = pin_i[`GP_IN_ONLY_BIT] & ~master_clear_enable_q;
    end

    assign dir_eff = dir_q | `GP_IN_ONLY_MASK | (xtal_q ? `GP_XTAL_MASK : 6'h00);
    assign wpu_rd = wpu_q | (xtal_q ? `GP_XTAL_MASK : 6'h00);

    assign mism = ioc_q & ~ana & (din ^ last_q);

    always_comb begin
        if (wb_adr_i == `GP_OFF_PORT) begin
            rsel = SEL_PORT;
        end else if (wb_adr_i == `GP_OFF_DIR) begin
            rsel = SEL_DIR;
        end else if (wb_adr_i == `GP_OFF_ANALOG_SELECT_LOW) begin
            rsel = SEL_ANALOG_SELECT_LOW;
        end else if (wb_adr_i == `GP_OFF_WPU) begin
            rsel = SEL_WPU;
        end else if (wb_adr_i == `GP_OFF_IOC) begin
            rsel = SEL_IOC;
        end else if (wb_adr_i == `GP_OFF_CFG) begin
            rsel = SEL_CFG;
        end else if (wb_adr_i == `GP_OFF_CTRL) begin
            rsel = SEL_CTRL;
        end else if (wb_adr_i == `GP_OFF_BSET) begin
            rsel = SEL_BSET;
        end else if (wb_adr_i == `GP_OFF_BCLR) begin
            rsel = SEL_BCLR;
        end else begin
            rsel = SEL_NONE;
        end
    end

    assign acc = wb_cyc_i & wb_stb_i & (st_q == BUS_IDLE);
    assign wr = acc & wb_we_i & wb_sel_i[0];
    assign rd = acc & ~wb_we_i;

    // bit-set and bit-clear writes start from the sampled pin levels
    assign set_val = din | wb_dat_i[5:0];
    assign clr_val = din & ~wb_dat_i[5:0];

    always_comb begin
        case (rsel)
            SEL_BSET: wr_val = set_val;
            SEL_BCLR: wr_val = clr_val;
            default: wr_val = wb_dat_i[5:0];
        endcase
    end

    // any read or write of the port refreshes the comparison value
    assign port_touch = (rd & (rsel == SEL_PORT))
        | (wr & ((rsel == SEL_PORT) | (rsel == SEL_BSET) | (rsel == SEL_BCLR)));
    assign flag_clr = wr & (rsel == SEL_CTRL) & wb_dat_i[`GP_CTRL_FLAG];

    always_comb begin
        case (rsel)
            SEL_PORT: rdat_d = word6(din);
            SEL_DIR: rdat_d = word6(dir_eff);
            SEL_ANALOG_SELECT_LOW: rdat_d = {24'h0, analog_select_low_q};
            SEL_WPU: rdat_d = word6(wpu_rd & ~`GP_IN_ONLY_MASK);
            SEL_IOC: rdat_d = word6(ioc_q);
            SEL_CFG: rdat_d = {30'h0, xtal_q, master_clear_enable_q};
            SEL_CTRL: rdat_d = {30'h0, pudis_q, flag_q};
            default: rdat_d = 32'h0000_0000;
        endcase
    end

    // bus handshake: one wait state, ack for one cycle
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= BUS_IDLE;
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            case (st_q)
                BUS_IDLE: begin
                    if (acc) begin
                        st_q <= BUS_ACK;
                        ack_q <= 1'b1;
                        rdat_q <= wb_we_i ? 32'h0000_0000 : rdat_d;
                    end
                end
                BUS_ACK: begin
                    st_q <= BUS_IDLE;
                    ack_q <= 1'b0;
                end
                default: begin
                    st_q <= BUS_IDLE;
                    ack_q <= 1'b0;
                end
            endcase
        end
    end

    // output latch and direction
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            latch_q <= `GP_RST_LATCH;
            dir_q <= `GP_RST_DIR;
        end else if (sys_rst) begin
            latch_q <= `GP_RST_LATCH;
            dir_q <= `GP_RST_DIR;
        end else if (wr) begin
            if ((rsel == SEL_PORT) | (rsel == SEL_BSET) | (rsel == SEL_BCLR)) begin
                latch_q <= wr_val;
            end
            if (rsel == SEL_DIR) begin
                dir_q <= wb_dat_i[5:0];
            end
        end
    end

    // analog, pull-up and change enables
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            analog_select_low_q <= `GP_RST_ANALOG_SELECT_LOW;
            wpu_q <= `GP_RST_WPU;
            ioc_q <= `GP_RST_IOC;
        end else if (sys_rst) begin
            analog_select_low_q <= `GP_RST_ANALOG_SELECT_LOW;
            wpu_q <= `GP_RST_WPU;
            ioc_q <= `GP_RST_IOC;
        end else if (wr) begin
            if (rsel == SEL_ANALOG_SELECT_LOW) begin
                analog_select_low_q <= wb_dat_i[7:0];
            end
            if (rsel == SEL_WPU) begin
                wpu_q <= wb_dat_i[5:0] & ~`GP_IN_ONLY_MASK;
            end
            if (rsel == SEL_IOC) begin
                ioc_q <= wb_dat_i[5:0];
            end
        end
    end

    // configuration and global pull-up disable
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            master_clear_enable_q <= `GP_RST_MASTER_CLEAR_ENABLE;
            xtal_q <= `GP_RST_XTAL;
            pudis_q <= `GP_RST_PUDIS;
        end else if (sys_rst) begin
            pudis_q <= `GP_RST_PUDIS;
        end else if (wr) begin
            if (rsel == SEL_CFG) begin
                master_clear_enable_q <= wb_dat_i[`GP_CFG_MASTER_CLEAR_ENABLE];
                xtal_q <= wb_dat_i[`GP_CFG_XTAL];
            end
            if (rsel == SEL_CTRL) begin
                pudis_q <= wb_dat_i[`GP_CTRL_PUDIS];
            end
        end
    end

    // last-read value, untouched by sys_rst
    // a change landing in the read cycle still mismatches the old value, so the flag sets
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            last_q <= `GP_RST_LATCH;
        end else if (port_touch) begin
            last_q <= din;
        end
    end

    // change flag: a mismatch wins over a clear in the same cycle
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            flag_q <= 1'b0;
            wake_q <= 1'b0;
        end else begin
            wake_q <= |mism;
            if (|mism) begin
                flag_q <= 1'b1;
            end else if (flag_clr | sys_rst) begin
                flag_q <= 1'b0;
            end
        end
    end

    always_comb begin
        ctl_d.dout = latch_q;
        // direction alone gates the driver, analog select plays no part
        ctl_d.oe = ~dir_eff;
        ctl_d.pu = wpu_q & dir_eff & ~ana & {6{~pudis_q}};
        ctl_d.pu[`GP_IN_ONLY_BIT] = master_clear_enable_q;
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctl_q <= '0;
        end else begin
            ctl_q <= ctl_d;
        end
    end

    assign pin_o = ctl_q.dout;
    assign pin_oe = ctl_q.oe;
    assign pullup_o = ctl_q.pu;
    assign wb_dat_o = rdat_q;
    assign wb_ack_o = ack_q;
    assign change_flag_o = flag_q;
    assign wake_o = wake_q;

    // checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);

    sequence port_read_s;
        rd && rsel == SEL_PORT;
    endsequence

    sequence dir_read_s;
        rd && rsel == SEL_DIR;
    endsequence

    sequence bset_s;
        wr && rsel == SEL_BSET && !sys_rst;
    endsequence

    AST_ACK_ONE: assert property (acc |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a one-cycle answer");
    AST_IN_ONLY_NO_DRIVE: assert property (!pin_oe[`GP_IN_ONLY_BIT])
        else $error("input-only pin driven");
    AST_DIR3_READS_ONE: assert property (dir_read_s |=> wb_dat_o[3] && wb_dat_o[7:6] == 2'b00)
        else $error("direction read back wrong");
    AST_XTAL_DIR: assert property (dir_read_s ##0 xtal_q |=> wb_dat_o[5:4] == 2'b11)
        else $error("oscillator direction bits not one");
    AST_ANALOG_ZERO: assert property (port_read_s ##0 analog_select_low_q[0] |=> !wb_dat_o[0])
        else $error("analog pin read not zero");
    AST_MASTER_CLEAR_ENABLE_ZERO: assert property (port_read_s ##0 master_clear_enable_q |=> !wb_dat_o[3])
        else $error("input-only bit not zero");
    AST_BSET_RMW: assert property (bset_s |=> latch_q == $past(set_val))
        else $error("bit set not read-modify-write");
    AST_OE_FOLLOWS_DIR: assert property (!dir_eff[0] |=> pin_oe[0] && pin_o[0] == $past(latch_q[0]))
        else $error("driver not following direction");
    AST_PU_OFF_OUTPUT: assert property ((pin_oe & pullup_o) == 6'h00)
        else $error("pull-up on an output");
    AST_PUDIS_GLOBAL: assert property (pudis_q |=> (pullup_o & ~`GP_IN_ONLY_MASK) == 6'h00)
        else $error("pull-up despite global disable");
    AST_FLAG_SET: assert property (|mism |=> change_flag_o && wake_o)
        else $error("mismatch did not set flag");
    AST_SYSRST_KEEPS_LAST: assert property (sys_rst && !port_touch |=> $stable(last_q))
        else $error("last-read value lost on reset");

    // bit-clear stores the sampled pins with the addressed bits cleared
    sequence bclr_s;
        wr && rsel == SEL_BCLR && !sys_rst;
    endsequence

    // no set and no clear: the flag keeps its level
    sequence flag_quiet_s;
        !(|mism) && !flag_clr && !sys_rst;
    endsequence

    // a clear or a reset with no mismatch pending
    sequence flag_clear_s;
        (flag_clr || sys_rst) && !(|mism);
    endsequence

    // bus, latch, change flag and driver checks
    AST_BCLR_RMW: assert property (bclr_s |=> latch_q == $past(clr_val))
        else $error("bit clear not read-modify-write");
    AST_LATCH_HOLD: assert property (!wr && !sys_rst |=> $stable(latch_q))
        else $error("output latch moved without a write");
    AST_ACK_ONLY_ON_REQ: assert property (!acc |=> !wb_ack_o)
        else $error("ack without a request");
    AST_UNMAPPED_ZERO: assert property (rd && rsel == SEL_NONE |=> !(|wb_dat_o))
        else $error("unmapped read not zero");
    AST_LAST_REFRESH: assert property (port_touch |=> last_q == $past(din))
        else $error("last-read value not refreshed");
    AST_FLAG_HOLD: assert property (flag_quiet_s |=> $stable(change_flag_o))
        else $error("change flag moved on its own");
    AST_FLAG_CLEAR: assert property (flag_clear_s |=> !change_flag_o)
        else $error("change flag not cleared");
    AST_WAKE_DROP: assert property (!(|mism) |=> !wake_o)
        else $error("wake without a mismatch");
    AST_ANALOG_DRIVES: assert property (!dir_eff[0] && analog_select_low_q[0] |=> pin_oe[0])
        else $error("analog select stopped the driver");
    AST_CRYSTAL_NO_DRIVE: assert property (xtal_q |=> pin_oe[5:4] == 2'b00)
        else $error("oscillator pin driven");

    // pull-up checks
    AST_PU_ANALOG_OFF: assert property ((pullup_o & $past(ana)) == 6'h00)
        else $error("pull-up on an analog pin");
    AST_PU_IN_ONLY_ON: assert property (arst_n && master_clear_enable_q |=> pullup_o[3])
        else $error("input-only pull-up off with master clear");
    AST_PU_IN_ONLY_OFF: assert property (!master_clear_enable_q |=> !pullup_o[3])
        else $error("input-only pull-up on without master clear");

endmodule
`default_nettype wire

//--- six_bit_port_params.svh
// register map, field positions, reset values of the six-bit port
// assumes a 32-bit classic wishbone slave, one aligned word per register
`ifndef SIX_BIT_PORT_PARAMS_SVH
`define SIX_BIT_PORT_PARAMS_SVH

`define GP_ADDR_W 8
`define GP_DATA_W 32

// byte offsets
`define GP_OFF_PORT 8'h00
`define GP_OFF_DIR 8'h04
`define GP_OFF_ANALOG_SELECT_LOW 8'h08
`define GP_OFF_WPU 8'h0C
`define GP_OFF_IOC 8'h10
`define GP_OFF_CFG 8'h14
`define GP_OFF_CTRL 8'h18
`define GP_OFF_BSET 8'h1C
`define GP_OFF_BCLR 8'h20

// pin masks
`define GP_IN_ONLY_BIT 3
`define GP_IN_ONLY_MASK 6'h08
`define GP_XTAL_MASK 6'h30

// field positions
`define GP_CFG_MASTER_CLEAR_ENABLE 0
`define GP_CFG_XTAL 1
`define GP_CTRL_FLAG 0
`define GP_CTRL_PUDIS 1

// reset values
`define GP_RST_DIR 6'h3F
`define GP_RST_ANALOG_SELECT_LOW 8'hFF
`define GP_RST_WPU 6'h37
`define GP_RST_IOC 6'h00
`define GP_RST_LATCH 6'h00
`define GP_RST_MASTER_CLEAR_ENABLE 1'b1
`define GP_RST_XTAL 1'b0
`define GP_RST_PUDIS 1'b1

`endif

//--- six_bit_port_pkg.sv
// types shared by the six-bit port
// assumes the constants header is included where offsets are needed
package six_bit_port_pkg;

    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_ACK = 1'b1
    } bus_st_t;

    typedef enum logic [3:0] {
        SEL_NONE = 4'h0,
        SEL_PORT = 4'h1,
        SEL_DIR = 4'h2,
        SEL_ANALOG_SELECT_LOW = 4'h3,
        SEL_WPU = 4'h4,
        SEL_IOC = 4'h5,
        SEL_CFG = 4'h6,
        SEL_CTRL = 4'h7,
        SEL_BSET = 4'h8,
        SEL_BCLR = 4'h9
    } reg_sel_t;

    typedef struct packed {
        logic [5:0] dout;
        logic [5:0] oe;
        logic [5:0] pu;
    } pin_ctl_t;

endpackage

//--- board_model.sv
// board model: pins driven by the port, by external circuits or by pull-ups
// assumes ext_en and ext_val change right after rising edges of ref_clk
`timescale 1ns/100ps
`default_nettype none
module board_model (
    input wire logic ref_clk, // core clock
    input wire logic [5:0] pin_o, // port drive value
    input wire logic [5:0] pin_oe, // port driver enable
    input wire logic [5:0] pullup_o, // weak pull-up on
    input wire logic [5:0] ext_en, // external driver present
    input wire logic [5:0] ext_val, // external drive value
    output logic [5:0] pin_i // resolved pin level
);
    logic [5:0] float_q = 6'h00;
    // an undriven pin wanders every cycle
    always_ff @(posedge ref_clk) begin
        float_q <= ~float_q;
    end
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            if (pin_oe[i]) begin
                pin_i[i] = pin_o[i];
            end else if (ext_en[i]) begin
                pin_i[i] = ext_val[i];
            end else if (pullup_o[i]) begin
                pin_i[i] = 1'b1;
            end else begin
                pin_i[i] = float_q[i];
            end
        end
    end
endmodule
`default_nettype wire

//--- six_bit_port_with_change_irq_tb.sv
// self-checking bench for the six-bit port with change detection
// assumes the board model and the design files are compiled before it
`timescale 1ns/100ps
`default_nettype none
`include "six_bit_port_params.svh"
module six_bit_port_with_change_irq_tb;
    import six_bit_port_pkg::*;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic sys_rst = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o, rd, d;
    logic wb_ack_o, change_flag_o, wake_o, master_clear_enable_s, xtal_s;
    logic [5:0] pin_i, pin_o, pin_oe, pullup_o, dir_s, lat_s;
    logic [5:0] ext_val = 6'h3F;
    logic [5:0] ext_en = 6'h3F;
    logic [3:0] lanes = 4'hF;
    logic [7:0] ans_s, adr;
    int miscompares = 0;
    int compares = 0;

    six_bit_port_with_change_irq dut_u (.ref_clk(ref_clk), .arst_n(arst_n),
        .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe),
        .pullup_o(pullup_o), .change_flag_o(change_flag_o), .wake_o(wake_o));
    board_model board_u (.ref_clk(ref_clk), .pin_o(pin_o), .pin_oe(pin_oe),
        .pullup_o(pullup_o), .ext_en(ext_en), .ext_val(ext_val), .pin_i(pin_i));

    function automatic logic [5:0] amask(input logic [7:0] a);
        return {1'b0, a[3], 1'b0, a[2:0]};
    endfunction
    function automatic logic [5:0] oe_exp();
        return ~dir_s & ~6'h08 & ~(xtal_s ? 6'h30 : 6'h00);
    endfunction
    function automatic logic [5:0] rd_exp();
        logic [5:0] p;
        // a released pin follows its external driver, else its pull-up
        p = (oe_exp() & lat_s) | (~oe_exp() & (ext_val | ~ext_en));
        return p & ~amask(ans_s) & ~(master_clear_enable_s ? 6'h08 : 6'h00);
    endfunction

    task automatic end_of_test();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string m);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic chk6(input logic [5:0] got, input logic [5:0] exp, input string m);
        chk32({26'h0, got}, {26'h0, exp}, m);
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] dat);
        int n;
        n = 0;
        @(posedge ref_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= lanes;
        wb_dat_i <= dat;
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (wb_ack_o !== 1'b1) begin
            miscompares++;
            $display("CHECK FAILED at %0t: bus timeout", $time);
            end_of_test();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] dat);
        wb(1'b1, a, dat);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string m);
        wb(1'b0, a, 32'h0);
        chk32(rd, exp, m);
    endtask
    task automatic settle();
        repeat (3) @(posedge ref_clk);
        #1;
    endtask

    initial begin
        forever #10 ref_clk = ~ref_clk;
    end

    initial begin
        void'($urandom(60));
        repeat (4) @(posedge ref_clk);
        arst_n <= 1'b1;
        dir_s = 6'h3F;
        lat_s = 6'h00;
        ans_s = 8'hFF;
        master_clear_enable_s = 1'b1;
        xtal_s = 1'b0;
        settle();
        chk6(pullup_o, 6'h08, "pullup after reset");
        chk6(pin_oe, 6'h00, "oe after reset");
        rdchk(`GP_OFF_DIR, 32'h3F, "dir reset");
        rdchk(`GP_OFF_ANALOG_SELECT_LOW, 32'hFF, "analog_select_low reset");
        rdchk(`GP_OFF_IOC, 32'h0, "ioc reset");
        rdchk(`GP_OFF_WPU, 32'h37, "wpu reset");
        rdchk(`GP_OFF_CTRL, 32'h2, "ctrl reset");
        rdchk(`GP_OFF_PORT, {26'h0, rd_exp()}, "analog port read");
        $display("test reset values done");
        wr(`GP_OFF_CFG, 32'h0);
        master_clear_enable_s = 1'b0;
        wr(`GP_OFF_ANALOG_SELECT_LOW, 32'h0);
        ans_s = 8'h00;
        for (int k = 0; k < 40; k++) begin
            @(posedge ref_clk);
            ext_val <= 6'($urandom);
            #1;
            d = $urandom;
            case (k % 4)
                0: begin
                    adr = `GP_OFF_PORT;
                    lat_s = d[5:0];
                end
                1: begin
                    adr = `GP_OFF_BSET;
                    lat_s = rd_exp() | d[5:0];
                end
                2: begin
                    adr = `GP_OFF_BCLR;
                    lat_s = rd_exp() & ~d[5:0];
                end
                default: begin
                    adr = `GP_OFF_DIR;
                    dir_s = d[5:0] | 6'h08;
                end
            endcase
            wr(adr, d);
            settle();
            chk6(pin_oe, oe_exp(), "driver enable");
            chk6(pin_o, lat_s, "output latch");
            rdchk(`GP_OFF_PORT, {26'h0, rd_exp()}, "port read");
            rdchk(`GP_OFF_DIR, {26'h0, dir_s}, "dir read");
        end
        $display("test random port traffic done");
        wr(`GP_OFF_DIR, 32'h08);
        dir_s = 6'h08;
        wr(`GP_OFF_PORT, 32'h3F);
        lat_s = 6'h3F;
        wr(`GP_OFF_ANALOG_SELECT_LOW, 32'h0F);
        ans_s = 8'h0F;
        settle();
        chk6(pin_oe, 6'h37, "analog output drive");
        chk6(pin_o, 6'h3F, "analog output latch");
        rdchk(`GP_OFF_PORT, {26'h0, rd_exp()}, "analog reads zero");
        wr(`GP_OFF_DIR, 32'h0F);
        dir_s = 6'h0F;
        wr(`GP_OFF_ANALOG_SELECT_LOW, 32'h01);
        ans_s = 8'h01;
        wr(`GP_OFF_WPU, 32'h3F);
        wr(`GP_OFF_CTRL, 32'h0);
        settle();
        chk6(pullup_o, 6'h06, "pullups on");
        rdchk(`GP_OFF_WPU, 32'h37, "wpu read");
        @(posedge ref_clk);
        ext_en <= 6'h39;
        settle();
        rdchk(`GP_OFF_PORT, {26'h0, rd_exp()}, "pulled-up pins");
        ext_en <= 6'h3F;
        wr(`GP_OFF_WPU, 32'h35);
        settle();
        chk6(pullup_o, 6'h04, "pullup bit zero off");
        wr(`GP_OFF_CTRL, 32'h2);
        settle();
        chk6(pullup_o, 6'h00, "global pullup off");
        wr(`GP_OFF_CFG, 32'h2);
        xtal_s = 1'b1;
        settle();
        chk6(pin_oe, oe_exp(), "crystal no drive");
        rdchk(`GP_OFF_DIR, {26'h0, dir_s | 6'h30}, "crystal dir");
        wr(`GP_OFF_CFG, 32'h0);
        xtal_s = 1'b0;
        $display("test analog pullup crystal done");
        wr(`GP_OFF_DIR, 32'h3F);
        wr(`GP_OFF_ANALOG_SELECT_LOW, 32'h0);
        @(posedge ref_clk);
        ext_val <= 6'h00;
        wr(`GP_OFF_IOC, 32'h02);
        wb(1'b0, `GP_OFF_PORT, 32'h0);
        wr(`GP_OFF_CTRL, 32'h3);
        @(posedge ref_clk);
        ext_val <= 6'h04;
        settle();
        chk6({5'h0, change_flag_o}, 6'h00, "disabled pin no flag");
        @(posedge ref_clk);
        ext_val <= 6'h06;
        settle();
        chk6({4'h0, change_flag_o, wake_o}, 6'h03, "flag and wake");
        wr(`GP_OFF_CTRL, 32'h3);
        settle();
        chk6({5'h0, change_flag_o}, 6'h01, "flag kept by mismatch");
        wb(1'b0, `GP_OFF_PORT, 32'h0);
        wr(`GP_OFF_CTRL, 32'h3);
        settle();
        chk6({4'h0, change_flag_o, wake_o}, 6'h00, "flag cleared");
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        @(posedge ref_clk);
        sys_rst <= 1'b0;
        wr(`GP_OFF_ANALOG_SELECT_LOW, 32'h0);
        wr(`GP_OFF_IOC, 32'h02);
        settle();
        chk6({5'h0, change_flag_o}, 6'h00, "last read kept");
        rdchk(`GP_OFF_CFG, 32'h0, "config kept");
        @(posedge ref_clk);
        ext_val <= 6'h04;
        settle();
        chk6({5'h0, change_flag_o}, 6'h01, "flag after reset");
        $display("test change detection done");
        wr(8'h40, 32'hFF);
        rdchk(8'h40, 32'h0, "unmapped read");
        rdchk(`GP_OFF_BSET, 32'h0, "set port read");
        lanes = 4'hE;
        wr(`GP_OFF_DIR, 32'h0);
        lanes = 4'hF;
        rdchk(`GP_OFF_DIR, 32'h3F, "write without lane 0");
        $display("test unmapped done");
        end_of_test();
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        $display("CHECK FAILED at %0t: run timeout", $time);
        end_of_test();
    end
endmodule
`default_nettype wire
